// ### rtl/pfc_pkg.sv
// shared constants and types of the parallel flash command host
package pfc_pkg;
   localparam int          ADDR_W            = 19;
   localparam int          DATA_W            = 16;
   localparam int          CLK_PERIOD_NS     = 40;
   // bus timing, nanoseconds, and cycle counts rounded up
   localparam int          T_WR_PULSE_NS     = 80;
   localparam int          T_RD_ACCESS_NS    = 120;
   localparam int          WR_PULSE_CYC      = (T_WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          RD_ACCESS_CYC     = (T_RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          SYNC_STAGES       = 2;
   localparam int          RD_WAIT_CYC       = RD_ACCESS_CYC + SYNC_STAGES;
   localparam int          CNT_W             = 4;
   // longest word program, rounded down to cycles
   localparam int          PROG_TIME_US      = 40;
   localparam int          PROG_TIMEOUT_CYC  = (PROG_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int          TIMER_W           = 32;
   // command sequence figures
   localparam int          PROG_STEPS        = 4;
   localparam int          ERASE_STEPS       = 6;
   localparam int          STEP_W            = 3;
   localparam logic [15:0] SECTOR_ERASE_CODE = 16'h0030;
   localparam logic [15:0] BLOCK_ERASE_CODE  = 16'h0050;
   localparam logic [15:0] CHIP_ERASE_CODE   = 16'h0010;
   localparam logic [18:0] CHIP_ERASE_ADDR   = 19'h05555;
   localparam int          SECTOR_LSB        = 11;
   localparam int          BLOCK_LSB         = 15;
   localparam int          TOGGLE_BIT        = 6;

   typedef enum logic [2:0] {
      OP_READ         = 3'h0,
      OP_PROGRAM      = 3'h1,
      OP_SECTOR_ERASE = 3'h2,
      OP_BLOCK_ERASE  = 3'h3,
      OP_CHIP_ERASE   = 3'h4
   } pfc_op_t;
endpackage : pfc_pkg

// ### rtl/pfc_cyc_if.sv
// one flash bus cycle request between sequencer and pin engine
`timescale 1ns/100ps
interface pfc_cyc_if;
   logic        req;
   logic        wr;
   logic [18:0] addr;
   logic [15:0] wdata;
   logic        done;
   logic [15:0] rdata;

   modport master (output req, output wr, output addr, output wdata, input done, input rdata);
   modport engine (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : pfc_cyc_if

// ### rtl/pfc_bus_cycle.sv
// pin engine: one asynchronous read or write cycle on the flash pins
`timescale 1ns/100ps
module pfc_bus_cycle
   import pfc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   pfc_cyc_if.engine        cyc,
   output logic             flash_ce_n,
   output logic             flash_oe_n,
   output logic             flash_we_n,
   output logic [18:0]      flash_addr,
   output logic [15:0]      flash_dq_o,
   output logic             flash_dq_oe,
   input  wire logic [15:0] flash_dq_i
);
   typedef enum logic [2:0] {
      E_IDLE   = 3'h0,
      E_SETUP  = 3'h1,
      E_PULSE  = 3'h2,
      E_HOLD   = 3'h3,
      E_RDWAIT = 3'h4,
      E_END    = 3'h5
   } pfc_eng_t;

   pfc_eng_t          state_q;
   logic [CNT_W-1:0]  cnt_q;
   logic [15:0]       dq_s1_q;
   logic [15:0]       dq_s2_q;
   logic [15:0]       rdata_q;
   logic              done_q;

   localparam logic [CNT_W-1:0] WP_LAST = CNT_W'(WR_PULSE_CYC - 1);
   localparam logic [CNT_W-1:0] RD_LAST = CNT_W'(RD_WAIT_CYC - 1);

   assign cyc.done  = done_q;
   assign cyc.rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= E_IDLE;
         cnt_q   <= '0;
      end else begin
         unique case (state_q)
            E_IDLE: begin
               cnt_q <= '0;
               if (cyc.req) begin
                  state_q <= cyc.wr ? E_SETUP : E_RDWAIT;
               end
            end
            E_SETUP: state_q <= E_PULSE;
            E_PULSE: begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == WP_LAST) begin
                  state_q <= E_HOLD;
               end
            end
            E_HOLD: state_q <= E_END;
            E_RDWAIT: begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == RD_LAST) begin
                  state_q <= E_END;
               end
            end
            E_END: state_q <= E_IDLE;
            default: state_q <= E_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pins: chip select falls first, write strobe later, both rise apart
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flash_ce_n  <= 1'b1;
         flash_oe_n  <= 1'b1;
         flash_we_n  <= 1'b1;
         flash_addr  <= '0;
         flash_dq_o  <= '0;
         flash_dq_oe <= 1'b0;
      end else begin
         unique case (state_q)
            E_IDLE: begin
               if (cyc.req) begin
                  flash_addr  <= cyc.addr;
                  flash_ce_n  <= 1'b0;
                  flash_oe_n  <= cyc.wr;
                  flash_dq_o  <= cyc.wdata;
                  flash_dq_oe <= cyc.wr;
               end
            end
            E_SETUP: flash_we_n <= 1'b0;
            E_PULSE: begin
               if (cnt_q == WP_LAST) begin
                  flash_we_n <= 1'b1;
               end
            end
            E_HOLD: begin
               flash_ce_n  <= 1'b1;
               flash_dq_oe <= 1'b0;
            end
            E_RDWAIT: begin
               if (cnt_q == RD_LAST) begin
                  flash_ce_n <= 1'b1;
                  flash_oe_n <= 1'b1;
               end
            end
            E_END: begin
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dq_s1_q <= '0;
         dq_s2_q <= '0;
      end else begin
         dq_s1_q <= flash_dq_i;
         dq_s2_q <= dq_s1_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= '0;
         done_q  <= 1'b0;
      end else begin
         done_q <= (state_q == E_HOLD) || (state_q == E_RDWAIT && cnt_q == RD_LAST);
         if (state_q == E_RDWAIT && cnt_q == RD_LAST) begin
            rdata_q <= dq_s2_q;
         end
      end
   end
endmodule : pfc_bus_cycle

// ### rtl/pfc_host_ctrl.sv
// host controller: reads, programs and erases a parallel NOR flash through its pins
`timescale 1ns/100ps
module pfc_host_ctrl
   import pfc_pkg::*;
#(
   parameter logic [18:0] UNLOCK_ADDR_A     = 19'h05555,
   parameter logic [18:0] UNLOCK_ADDR_B     = 19'h02aaa,
   parameter logic [15:0] UNLOCK_DATA_A     = 16'h00aa,
   parameter logic [15:0] UNLOCK_DATA_B     = 16'h0055,
   parameter logic [15:0] PROGRAM_CODE      = 16'h00a0,
   parameter logic [15:0] ERASE_SETUP_CODE  = 16'h0080,
   parameter int          ERASE_TIMEOUT_CYC = 2500000
)
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             cmd_valid,
   output logic                  cmd_ready,
   input  wire pfc_pkg::pfc_op_t cmd_op,
   input  wire logic [18:0]      cmd_addr,
   input  wire logic [15:0]      cmd_wdata,
   output logic                  rsp_valid,
   output logic [15:0]           rsp_rdata,
   output logic                  rsp_timeout,
   output logic                  busy,
   output logic                  flash_ce_n,
   output logic                  flash_oe_n,
   output logic                  flash_we_n,
   output logic [18:0]           flash_addr,
   output logic [15:0]           flash_dq_o,
   output logic                  flash_dq_oe,
   input  wire logic [15:0]      flash_dq_i
);
   import pfc_pkg::*;

   typedef enum logic [1:0] {
      S_IDLE = 2'h0,
      S_SEQ  = 2'h1,
      S_POLL = 2'h2,
      S_READ = 2'h3
   } pfc_state_t;

   pfc_state_t         state_q;
   pfc_op_t            op_q;
   logic [18:0]        addr_q;
   logic [15:0]        wdata_q;
   logic [STEP_W-1:0]  step_q;
   logic [TIMER_W-1:0] timer_q;
   logic               poll_first_q;
   logic               toggle_prev_q;
   logic               rsp_valid_q;
   logic [15:0]        rsp_rdata_q;
   logic               rsp_timeout_q;
   logic [STEP_W-1:0]  last_step;
   logic [TIMER_W-1:0] timeout_lim;
   logic [18:0]        step_addr;
   logic [15:0]        step_data;
   logic               poll_settled;
   logic               poll_expired;

   pfc_cyc_if cyc ();

   ////////////////////////////////////////////////////////////////////////
   // write sequence table
   function automatic logic [18:0] target_addr(input pfc_op_t op, input logic [18:0] a);
      logic [18:0] sec_mask;
      logic [18:0] blk_mask;
      sec_mask = ~((19'h00001 << SECTOR_LSB) - 19'h00001);
      blk_mask = ~((19'h00001 << BLOCK_LSB) - 19'h00001);
      unique case (op)
         OP_SECTOR_ERASE: target_addr = a & sec_mask;
         OP_BLOCK_ERASE:  target_addr = a & blk_mask;
         OP_CHIP_ERASE:   target_addr = CHIP_ERASE_ADDR;
         default:         target_addr = a;
      endcase
   endfunction : target_addr

   always_comb begin
      step_addr = UNLOCK_ADDR_A;
      step_data = UNLOCK_DATA_A;
      if (op_q == OP_PROGRAM) begin
         unique case (step_q)
            3'h0: begin
               step_addr = UNLOCK_ADDR_A;
               step_data = UNLOCK_DATA_A;
            end
            3'h1: begin
               step_addr = UNLOCK_ADDR_B;
               step_data = UNLOCK_DATA_B;
            end
            3'h2: begin
               step_addr = UNLOCK_ADDR_A;
               step_data = PROGRAM_CODE;
            end
            default: begin
               step_addr = addr_q;
               step_data = wdata_q;
            end
         endcase
      end else begin
         unique case (step_q)
            3'h0, 3'h3: begin
               step_addr = UNLOCK_ADDR_A;
               step_data = UNLOCK_DATA_A;
            end
            3'h1, 3'h4: begin
               step_addr = UNLOCK_ADDR_B;
               step_data = UNLOCK_DATA_B;
            end
            3'h2: begin
               step_addr = UNLOCK_ADDR_A;
               step_data = ERASE_SETUP_CODE;
            end
            default: begin
               step_addr = target_addr(op_q, addr_q);
               unique case (op_q)
                  OP_SECTOR_ERASE: step_data = SECTOR_ERASE_CODE;
                  OP_BLOCK_ERASE:  step_data = BLOCK_ERASE_CODE;
                  default:         step_data = CHIP_ERASE_CODE;
               endcase
            end
         endcase
      end
   end

   assign last_step   = (op_q == OP_PROGRAM) ? STEP_W'(PROG_STEPS - 1) : STEP_W'(ERASE_STEPS - 1);
   assign timeout_lim = (op_q == OP_PROGRAM) ? TIMER_W'(PROG_TIMEOUT_CYC) : TIMER_W'(ERASE_TIMEOUT_CYC);

   ////////////////////////////////////////////////////////////////////////
   // cycle requests: status reads only while the flash is busy
   assign cyc.req   = (state_q != S_IDLE);
   assign cyc.wr    = (state_q == S_SEQ);
   assign cyc.addr  = (state_q == S_SEQ) ? step_addr : target_addr(op_q, addr_q);
   assign cyc.wdata = step_data;

   // toggle bit stops changing once the operation is done
   assign poll_settled = !poll_first_q && (cyc.rdata[TOGGLE_BIT] == toggle_prev_q);
   assign poll_expired = (timer_q >= timeout_lim);

   assign cmd_ready   = (state_q == S_IDLE);
   assign busy        = (state_q == S_POLL);
   assign rsp_valid   = rsp_valid_q;
   assign rsp_rdata   = rsp_rdata_q;
   assign rsp_timeout = rsp_timeout_q;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= S_IDLE;
         step_q  <= '0;
      end else begin
         unique case (state_q)
            S_IDLE: begin
               step_q <= '0;
               if (cmd_valid) begin
                  state_q <= (cmd_op == OP_READ) ? S_READ : S_SEQ;
               end
            end
            S_SEQ: begin
               if (cyc.done) begin
                  step_q <= step_q + 1'b1;
                  if (step_q == last_step) begin
                     state_q <= S_POLL;
                  end
               end
            end
            S_POLL: begin
               if (cyc.done && (poll_settled || poll_expired)) begin
                  state_q <= S_IDLE;
               end
            end
            S_READ: begin
               if (cyc.done) begin
                  state_q <= S_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         op_q    <= OP_READ;
         addr_q  <= '0;
         wdata_q <= '0;
      end else if (state_q == S_IDLE && cmd_valid) begin
         op_q    <= cmd_op;
         addr_q  <= cmd_addr;
         wdata_q <= cmd_wdata;
      end
   end

   // polling timer and previous toggle sample
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_q       <= '0;
         poll_first_q  <= 1'b1;
         toggle_prev_q <= 1'b0;
      end else if (state_q != S_POLL) begin
         timer_q      <= '0;
         poll_first_q <= 1'b1;
      end else begin
         if (!poll_expired) begin
            timer_q <= timer_q + 1'b1;
         end
         if (cyc.done) begin
            poll_first_q  <= 1'b0;
            toggle_prev_q <= cyc.rdata[TOGGLE_BIT];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_valid_q   <= 1'b0;
         rsp_rdata_q   <= '0;
         rsp_timeout_q <= 1'b0;
      end else begin
         rsp_valid_q <= 1'b0;
         if (state_q == S_READ && cyc.done) begin
            rsp_valid_q   <= 1'b1;
            rsp_rdata_q   <= cyc.rdata;
            rsp_timeout_q <= 1'b0;
         end else if (state_q == S_POLL && cyc.done && (poll_settled || poll_expired)) begin
            rsp_valid_q   <= 1'b1;
            rsp_rdata_q   <= cyc.rdata;
            rsp_timeout_q <= !poll_settled;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   pfc_bus_cycle u_bus_cycle (
      .clk         (clk),
      .rst_n       (rst_n),
      .cyc         (cyc.engine),
      .flash_ce_n  (flash_ce_n),
      .flash_oe_n  (flash_oe_n),
      .flash_we_n  (flash_we_n),
      .flash_addr  (flash_addr),
      .flash_dq_o  (flash_dq_o),
      .flash_dq_oe (flash_dq_oe),
      .flash_dq_i  (flash_dq_i)
   );
endmodule : pfc_host_ctrl

// ### tb/pfc_host_ctrl_chk.sv
// pin-level assertions of the flash host controller
`timescale 1ns/100ps
module pfc_host_ctrl_chk
   import pfc_pkg::*;
(
   input wire logic             clk,
   input wire logic             rst_n,
   input wire logic             cmd_valid,
   input wire logic             cmd_ready,
   input wire pfc_pkg::pfc_op_t cmd_op,
   input wire logic [18:0]      cmd_addr,
   input wire logic [15:0]      cmd_wdata,
   input wire logic             rsp_valid,
   input wire logic [15:0]      rsp_rdata,
   input wire logic             rsp_timeout,
   input wire logic             busy,
   input wire logic             flash_ce_n,
   input wire logic             flash_oe_n,
   input wire logic             flash_we_n,
   input wire logic [18:0]      flash_addr,
   input wire logic [15:0]      flash_dq_o,
   input wire logic             flash_dq_oe,
   input wire logic [15:0]      flash_dq_i
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic take;
   assign take = cmd_valid && cmd_ready;
   ////////////////////////////////////////////////////////////////////////////
   a_we_with_ce: assert property (!flash_we_n |-> !flash_ce_n) else $error("strobe without select");
   a_no_rd_wr: assert property (!flash_we_n |-> flash_oe_n) else $error("read and write at once");
   a_no_bus_fight: assert property (!flash_oe_n |-> !flash_dq_oe) else $error("host drives while gated");
   a_read_gate: assert property ($fell(flash_oe_n) |-> !flash_ce_n && flash_we_n)
      else $error("read without select");
   a_addr_steady: assert property (!flash_we_n |-> $stable(flash_addr) && flash_dq_oe)
      else $error("address moved in strobe");
   a_data_hold: assert property ($rose(flash_we_n) |-> flash_dq_oe && $stable(flash_dq_o) && !flash_ce_n)
      else $error("data not held at strobe rise");
   a_strobe_width: assert property ($fell(flash_we_n) |=> !flash_we_n ##1 flash_we_n)
      else $error("strobe width wrong");
   a_busy_no_write: assert property (busy |-> flash_we_n && !cmd_ready) else $error("write while busy");
   a_read_latency: assert property (take && cmd_op == OP_READ |-> ##8 rsp_valid)
      else $error("read answer late");
   a_unlock_first: assert property (take && cmd_op != OP_READ |->
      ##[1:6] (!flash_we_n && flash_addr == 19'h05555 && flash_dq_o == 16'h00aa)) else $error("no unlock write");
   a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid) else $error("response not a pulse");
endmodule : pfc_host_ctrl_chk

bind pfc_host_ctrl pfc_host_ctrl_chk pfc_host_ctrl_chk_i (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
   .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
   .rsp_rdata(rsp_rdata), .rsp_timeout(rsp_timeout), .busy(busy), .flash_ce_n(flash_ce_n),
   .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
   .flash_dq_oe(flash_dq_oe), .flash_dq_i(flash_dq_i));

// ### tb/pfc_flash_model.sv
// behavioural model of the asynchronous parallel flash device
`timescale 1ns/100ps
module pfc_flash_model #(
   parameter int BUSY_READS = 3
)
(
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic [18:0] addr,
   input  wire logic [15:0] din,
   input  wire logic        stall,
   output logic [15:0]      dout
);
   logic [15:0] mem [int];
   logic [18:0] a_lat;
   logic [2:0]  step = 3'h0;
   int          busy_n = 0;
   logic        erasing = 1'b0;
   logic        tog = 1'b0;
   logic [15:0] pd = 16'h0000;
   logic [15:0] val;
   logic [15:0] last_q = 16'h0000;
   wire         wr_n = ce_n | we_n;
   wire         rd_n = ce_n | oe_n;
   function automatic logic [15:0] rd(input int a);
      return mem.exists(a) ? mem[a] : 16'hffff;
   endfunction : rd
   function automatic logic ok(input logic [18:0] a, input logic [7:0] d);
      return a_lat == a && din[7:0] == d;
   endfunction : ok
   task automatic erase_rng(input int base, input int n);
      for (int i = 0; i < n; i++) mem.delete(base + i);
      erasing = 1'b1;
      busy_n = BUSY_READS;
   endtask : erase_rng
   ////////////////////////////////////////////////////////////////////////////
   always @(negedge wr_n) a_lat = addr;
   always @(posedge wr_n) begin
      if (busy_n == 0) begin
         case (step)
            3'h0: step = ok(19'h05555, 8'haa) ? 3'h1 : 3'h0;
            3'h1: step = ok(19'h02aaa, 8'h55) ? 3'h2 : 3'h0;
            3'h2: step = ok(19'h05555, 8'ha0) ? 3'h6 : (ok(19'h05555, 8'h80) ? 3'h3 : 3'h0);
            3'h3: step = ok(19'h05555, 8'haa) ? 3'h4 : 3'h0;
            3'h4: step = ok(19'h02aaa, 8'h55) ? 3'h5 : 3'h0;
            3'h5: begin
               if (ok(19'h05555, 8'h10)) erase_rng(0, 0);
               if (ok(19'h05555, 8'h10)) mem.delete();
               else if (din[7:0] == 8'h30) erase_rng(a_lat & 19'h7f800, 'h800);
               else if (din[7:0] == 8'h50) erase_rng(a_lat & 19'h78000, 'h8000);
               step = 3'h0;
            end
            default: begin
               mem[a_lat] = rd(a_lat) & din;
               pd = din;
               erasing = 1'b0;
               busy_n = BUSY_READS;
               step = 3'h0;
            end
         endcase
      end
   end
   always @(negedge rd_n) begin
      if (busy_n > 0) begin
         tog = ~tog;
         if (!stall) busy_n--;
      end
   end
   always @(rd_n or addr or busy_n or tog or erasing or pd) begin
      val = busy_n > 0 ? {8'h00, erasing ? 1'b0 : ~pd[7], tog, 6'h00} : rd(addr);
   end
   always @(posedge rd_n) last_q = val;
   assign dout = !rd_n ? val : ~last_q;
endmodule : pfc_flash_model

// ### tb/pfc_host_ctrl_tb.sv
// self-checking bench of the flash host controller
`timescale 1ns/100ps
module pfc_host_ctrl_tb;
   import pfc_pkg::*;
   logic clk, rst_n, cmd_valid, cmd_ready, rsp_valid, rsp_timeout, busy, stall;
   logic ce_n, oe_n, we_n, dq_oe, r_to, saw_busy;
   logic [18:0] cmd_addr, f_addr;
   logic [15:0] cmd_wdata, rsp_rdata, dq_o, dq_i, r_data;
   pfc_op_t cmd_op;
   int n_mismatch = 0;
   int samples_checked = 0;
   pfc_host_ctrl #(.ERASE_TIMEOUT_CYC(200)) pfc_host_ctrl_i (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .rsp_timeout(rsp_timeout), .busy(busy), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
      .flash_we_n(we_n), .flash_addr(f_addr), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_i));
   pfc_flash_model pfc_flash_model_i (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(f_addr),
      .din(dq_oe ? dq_o : ~dq_o), .stall(stall), .dout(dq_i));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic do_cmd(input pfc_op_t op, input logic [18:0] a, input logic [15:0] d);
      int n;
      @(negedge clk);
      cmd_op = op;
      {cmd_valid, cmd_addr, cmd_wdata, saw_busy} = {1'b1, a, d, 1'b0};
      n = 0;
      while (cmd_ready !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      if (n >= 100) begin
         chk(16'hbeef, 16'h0000);
         tally_and_finish();
      end
      @(negedge clk);
      cmd_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 20000) begin
         if (busy === 1'b1) saw_busy = 1'b1;
         @(negedge clk);
         n++;
      end
      if (n >= 20000 || cmd_ready !== 1'b0 && n == 0) begin
         chk(16'hdead, 16'h0000);
         tally_and_finish();
      end
      {r_data, r_to} = {rsp_rdata, rsp_timeout};
   endtask : do_cmd
   task automatic rd_chk(input logic [18:0] a, input logic [15:0] exp);
      do_cmd(OP_READ, a, 16'h0000);
      chk(r_data, exp);
   endtask : rd_chk
   task automatic op_chk(input pfc_op_t op, input logic [18:0] a, input logic [15:0] d);
      do_cmd(op, a, d);
      chk({14'h0, saw_busy, r_to}, 16'h0002);
   endtask : op_chk
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk({12'h0, cmd_ready, ce_n, we_n, dq_oe}, 16'h000e);
      rd_chk(19'h7ffff, 16'hffff);
   endtask : t_reset
   task automatic t_program();
      op_chk(OP_PROGRAM, 19'h00812, 16'h1234);
      chk(r_data, 16'h1234);
      op_chk(OP_PROGRAM, 19'h01000, 16'h5a5a);
      rd_chk(19'h00812, 16'h1234);
      rd_chk(19'h01000, 16'h5a5a);
   endtask : t_program
   task automatic t_sector_erase();
      op_chk(OP_SECTOR_ERASE, 19'h00abc, 16'h0000);
      rd_chk(19'h00812, 16'hffff);
      rd_chk(19'h01000, 16'h5a5a);
   endtask : t_sector_erase
   task automatic t_block_erase();
      op_chk(OP_PROGRAM, 19'h0fff0, 16'h0f0f);
      op_chk(OP_PROGRAM, 19'h10000, 16'ha5a5);
      op_chk(OP_BLOCK_ERASE, 19'h08123, 16'h0000);
      rd_chk(19'h0fff0, 16'hffff);
      rd_chk(19'h10000, 16'ha5a5);
   endtask : t_block_erase
   task automatic t_chip_erase();
      op_chk(OP_CHIP_ERASE, 19'h12345, 16'h0000);
      rd_chk(19'h10000, 16'hffff);
      rd_chk(19'h01000, 16'hffff);
   endtask : t_chip_erase
   task automatic t_timeout();
      stall = 1'b1;
      do_cmd(OP_SECTOR_ERASE, 19'h20000, 16'h0000);
      chk({15'h0, r_to}, 16'h0001);
      stall = 1'b0;
   endtask : t_timeout
   initial begin
      {rst_n, cmd_valid, stall} = 3'b000;
      cmd_op = OP_READ;
      {cmd_addr, cmd_wdata} = {19'h00000, 16'h0000};
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      t_program();
      t_sector_erase();
      t_block_erase();
      t_chip_erase();
      t_timeout();
      tally_and_finish();
   end
endmodule : pfc_host_ctrl_tb
